/* rtl/sgrc_pkg.sv */
// Package for the stepped gain ramp control block: widths, limits,
// reset values and the ramp state encoding.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package sgrc_pkg;
    // Attenuation is counted in half steps of 0.05 dB
    localparam int ATT_W = 10;
    localparam logic [ATT_W-1:0] ATT_MAX_38DB = 10'h2f8; // 760 units
    localparam logic [ATT_W-1:0] ATT_MAX_36DB = 10'h2d0; // 720 units
    localparam logic [ATT_W-1:0] ATT_MAX_34DB = 10'h2a8; // 680 units
    localparam logic [ATT_W-1:0] ATT_MAX_32DB = 10'h280; // 640 units
    localparam logic [ATT_W-1:0] ATT_MIN = 10'h000;
    localparam logic [ATT_W-1:0] UNITS_HALF = 10'h001; // 0.05 dB
    localparam logic [ATT_W-1:0] UNITS_FULL = 10'h002; // 0.1 dB
    // Range select codes
    localparam logic [1:0] RANGE_38DB = 2'h0;
    localparam logic [1:0] RANGE_36DB = 2'h1;
    localparam logic [1:0] RANGE_34DB = 2'h2;
    localparam logic [1:0] RANGE_32DB = 2'h3;
    localparam logic [1:0] RANGE_RESET = 2'h0;
    // Pin synchroniser depth and bit positions
    localparam int SYNC_STAGES = 3;
    localparam int PIN_N = 3;
    localparam int PIN_STEP_CLK = 0;
    localparam int PIN_RAMP_RST = 1;
    localparam int PIN_DIR = 2;
    // Ramp reset idles high, so the ramp stays held through reset
    localparam logic [PIN_N-1:0] PIN_RESET = 3'h2;
    // Offset trim storage: eight channels, two amplifiers each
    localparam int CHAN_W = 3;
    localparam int TRIM_W = 8;
    localparam int TRIM_AW = CHAN_W + 1;
    localparam int TRIM_DEPTH = 16;
    localparam logic [TRIM_W-1:0] TRIM_RESET = 8'h80; // Mid-scale
    // Ramp state
    typedef enum logic [0:0] {
        SGRC_HOLD = 1'b0,
        SGRC_RAMP = 1'b1
    } sgrc_state_t;
endpackage
`default_nettype wire

/* rtl/sgrc_ramp_ctrl.sv */
// Stepped gain ramp control: keeps the attenuator setting from the
// step clock, ramp reset and direction pins, plus offset trim storage.
// Assumes the three pins are asynchronous to clk_i and that each pin
// level lasts well over four clk_i cycles; config inputs are on clk_i.
//
// Summary of operation
// - Attenuation spans zero to 38/36/34/32 dB
// - Step size 0.05 dB or 0.1 dB
// - Low reset: step clock rise moves one step
// - Reset fall starts ramp, stepping while low
// - Reset rise restores the initial attenuation
// - Direction input selects gain up or down
// - Initial point: max attenuation if up
// - Direction may change mid-ramp without reset
// - Volatile trims written after power-up
// - Independent trim for every channel
// - Half-step: both edges; disabled: rise full step
// - First rise after direction change only syncs
// - First rise after reset fall steps
// - No step edges: attenuation holds
`timescale 1ns/1ns
`default_nettype none
module sgrc_ramp_ctrl
    import sgrc_pkg::*;
(
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic gain_step_clock_i,
    input wire logic gain_ramp_reset_i,
    input wire logic gain_direction_i,
    input wire logic [1:0] range_sel_i,
    input wire logic half_step_disable_i,
    input wire logic trim_wr_en_i,
    input wire logic [CHAN_W-1:0] trim_wr_chan_i,
    input wire logic trim_wr_post_i,
    input wire logic [TRIM_W-1:0] trim_wr_data_i,
    input wire logic [CHAN_W-1:0] trim_rd_chan_i,
    input wire logic trim_rd_post_i,
    output logic [TRIM_W-1:0] trim_rd_data_o,
    output logic [ATT_W-1:0] attenuation_o,
    output logic ramp_active_o,
    output logic gain_up_o
);

    ////////////////////////////////////////////////////////////////////
    // Decode of the range code into the attenuation ceiling
    function automatic logic [ATT_W-1:0] sgrc_limit(input logic [1:0] r);
        case (r)
            RANGE_38DB: sgrc_limit = ATT_MAX_38DB;
            RANGE_36DB: sgrc_limit = ATT_MAX_36DB;
            RANGE_34DB: sgrc_limit = ATT_MAX_34DB;
            RANGE_32DB: sgrc_limit = ATT_MAX_32DB;
            default: sgrc_limit = ATT_MAX_38DB;
        endcase
    endfunction

    // One step with saturation at both ends; up means less attenuation
    function automatic logic [ATT_W-1:0] sgrc_step(
        input logic [ATT_W-1:0] att,
        input logic up,
        input logic [ATT_W-1:0] units,
        input logic [ATT_W-1:0] lim
    );
        if (up) begin
            sgrc_step = (att > units) ? att - units : ATT_MIN;
        end else begin
            sgrc_step = (lim - att > units) ? att + units : lim;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Pin synchronisers: three stages, a level counts once stages two
    // and three agree, so a single-cycle glitch never reaches the ramp
    logic [PIN_N-1:0] pins;
    logic [PIN_N-1:0] filt;
    logic [PIN_N-1:0] filt_q;

    assign pins = {gain_direction_i, gain_ramp_reset_i, gain_step_clock_i};

    genvar gp;
    generate
        for (gp = 0; gp < PIN_N; gp++) begin : g_sync
            logic [SYNC_STAGES-1:0] sync;
            always_ff @(posedge clk_i or negedge arst_n_i) begin
                if (!arst_n_i) begin
                    // Idle level, so no false edge or ramp follows reset
                    sync <= {SYNC_STAGES{PIN_RESET[gp]}};
                end else begin
                    sync <= {sync[SYNC_STAGES-2:0], pins[gp]};
                end
            end
            // Only stages two and three feed the filter
            always_ff @(posedge clk_i or negedge arst_n_i) begin
                if (!arst_n_i) begin
                    filt[gp] <= PIN_RESET[gp];
                end else if (sync[1] == sync[2]) begin
                    filt[gp] <= sync[1];
                end
            end
        end
    endgenerate

    // Previous filtered levels for edge detection
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            filt_q <= PIN_RESET;
        end else begin
            filt_q <= filt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Edge events and levels on the filtered pins
    logic clk_rise;
    logic clk_fall;
    logic rst_lvl;
    logic dir_lvl;

    assign clk_rise = filt[PIN_STEP_CLK] & ~filt_q[PIN_STEP_CLK];
    assign clk_fall = ~filt[PIN_STEP_CLK] & filt_q[PIN_STEP_CLK];
    assign rst_lvl = filt[PIN_RAMP_RST];
    assign dir_lvl = filt[PIN_DIR];

    ////////////////////////////////////////////////////////////////////
    sgrc_state_t state;
    logic [ATT_W-1:0] att;
    logic [ATT_W-1:0] lim;
    logic dir_eff;
    logic dir_change;
    logic [ATT_W-1:0] step_units;

    assign dir_change = (dir_lvl != dir_eff);
    // Rising edge moves a full step unless half-step mode is on
    assign step_units = half_step_disable_i ? UNITS_FULL : UNITS_HALF;

    // Ramp state: reset high holds, reset low ramps
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state <= SGRC_HOLD;
        end else begin
            case (state)
                SGRC_HOLD: begin
                    if (!rst_lvl) begin
                        state <= SGRC_RAMP;
                    end
                end
                SGRC_RAMP: begin
                    if (rst_lvl) begin
                        state <= SGRC_HOLD;
                    end
                end
                default: state <= SGRC_HOLD;
            endcase
        end
    end

    // Ceiling sampled only while reset is high, so a range change
    // mid-ramp cannot jump the attenuation
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            lim <= ATT_MAX_38DB;
        end else if (rst_lvl) begin
            lim <= sgrc_limit(range_sel_i);
        end
    end

    // Effective direction: loaded directly while reset is high, and
    // otherwise taken over only on a rising step edge
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            dir_eff <= 1'b0;
        end else if (rst_lvl) begin
            dir_eff <= dir_lvl;
        end else if (state == SGRC_RAMP && clk_rise) begin
            dir_eff <= dir_lvl;
        end
    end

    // Attenuation value
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            att <= ATT_MIN;
        end else if (rst_lvl) begin
            // Gain up starts at full attenuation, gain down at none
            att <= dir_lvl ? sgrc_limit(range_sel_i) : ATT_MIN;
        end else if (state == SGRC_RAMP) begin
            if (clk_rise && !dir_change) begin
                att <= sgrc_step(att, dir_eff, step_units, lim);
            end else if (clk_fall && !half_step_disable_i) begin
                att <= sgrc_step(att, dir_eff, UNITS_HALF, lim);
            end
            // No edge: value held as long as needed
        end
    end

    assign attenuation_o = att;
    assign ramp_active_o = (state == SGRC_RAMP);
    assign gain_up_o = dir_eff;

    ////////////////////////////////////////////////////////////////////
    // Per-channel trim words, addressed by channel and amplifier
    sgrc_trim_mem u_trim (
        .clk_i(clk_i),
        .arst_n_i(arst_n_i),
        .wr_en_i(trim_wr_en_i),
        .wr_addr_i({trim_wr_chan_i, trim_wr_post_i}),
        .wr_data_i(trim_wr_data_i),
        .rd_addr_i({trim_rd_chan_i, trim_rd_post_i}),
        .rd_data_o(trim_rd_data_o)
    );

    ////////////////////////////////////////////////////////////////////
    // Checks on stepping, saturation, reset load and the pin filter
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);

    chk_att_within_limit: assert property (
        att <= lim)
        else $error("attenuation beyond configured ceiling");

    chk_reset_initial_point: assert property (
        rst_lvl |=> att == (dir_eff ? lim : ATT_MIN))
        else $error("attenuation not at initial point during reset");

    chk_ramp_starts: assert property (
        (state == SGRC_HOLD && !rst_lvl) |=> state == SGRC_RAMP)
        else $error("ramp did not start after reset fell");

    chk_hold_no_edge: assert property (
        (state == SGRC_RAMP && !rst_lvl && !clk_rise && !clk_fall)
        |=> $stable(att))
        else $error("attenuation moved without a step edge");

    chk_full_step_up: assert property (
        (state == SGRC_RAMP && !rst_lvl && clk_rise && !dir_change
         && half_step_disable_i && dir_eff && att >= UNITS_FULL)
        |=> att == $past(att) - UNITS_FULL)
        else $error("full step up not taken on rising edge");

    chk_fall_half_down: assert property (
        (state == SGRC_RAMP && !rst_lvl && clk_fall
         && !half_step_disable_i && !dir_eff && att + UNITS_HALF < lim)
        |=> att == $past(att) + UNITS_HALF)
        else $error("half step not taken on falling edge");

    chk_fall_ignored: assert property (
        (state == SGRC_RAMP && !rst_lvl && clk_fall && half_step_disable_i)
        |=> $stable(att))
        else $error("falling edge moved attenuation in full-step mode");

    chk_dir_sync_only: assert property (
        (state == SGRC_RAMP && !rst_lvl && clk_rise && dir_change)
        |=> $stable(att) && dir_eff == $past(dir_lvl))
        else $error("direction change edge did more than sync");

    chk_limit_frozen: assert property (
        (state == SGRC_RAMP && !rst_lvl) |=> $stable(lim))
        else $error("attenuation ceiling changed during a ramp");

    chk_pin_filter: assert property (
        $changed(filt[PIN_STEP_CLK]) |-> $past(g_sync[PIN_STEP_CLK].sync[2])
        == $past(g_sync[PIN_STEP_CLK].sync[1]))
        else $error("step clock level passed without agreement");

    chk_ramp_ends: assert property (
        (state == SGRC_RAMP && rst_lvl) |=> state == SGRC_HOLD)
        else $error("ramp did not end when reset rose");

    chk_hold_no_step: assert property (
        (state == SGRC_HOLD && !rst_lvl) |=> $stable(att))
        else $error("attenuation moved before the ramp started");

    chk_half_rise_up: assert property (
        (state == SGRC_RAMP && !rst_lvl && clk_rise && !dir_change
         && !half_step_disable_i && dir_eff && att >= UNITS_HALF)
        |=> att == $past(att) - UNITS_HALF)
        else $error("half step not taken on rising edge");

    chk_full_step_down: assert property (
        (state == SGRC_RAMP && !rst_lvl && clk_rise && !dir_change
         && half_step_disable_i && !dir_eff && att + UNITS_FULL <= lim)
        |=> att == $past(att) + UNITS_FULL)
        else $error("full step down not taken on rising edge");

    chk_dir_loaded: assert property (
        rst_lvl |=> gain_up_o == $past(dir_lvl))
        else $error("direction not loaded while reset high");

    chk_range_at_reset: assert property (
        rst_lvl |=> lim == sgrc_limit($past(range_sel_i)))
        else $error("ceiling not taken from range while reset high");

    cov_step_taken: cover property (
        state == SGRC_RAMP && clk_rise && !dir_change ##1 $changed(att));
    cov_dir_change: cover property (
        state == SGRC_RAMP && clk_rise && dir_change);
    cov_sat_zero: cover property (
        state == SGRC_RAMP && att == ATT_MIN && clk_rise && dir_eff);
    cov_half_fall: cover property (
        state == SGRC_RAMP && clk_fall && !half_step_disable_i);

endmodule // sgrc_ramp_ctrl
`default_nettype wire

/* rtl/sgrc_trim_mem.sv */
// Offset trim storage: one word per channel and amplifier, one write
// port and one read port with a registered read.
// Assumes write and read requests come from logic on the same clock.
`timescale 1ns/1ns
`default_nettype none
module sgrc_trim_mem
    import sgrc_pkg::*;
(
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic wr_en_i,
    input wire logic [TRIM_AW-1:0] wr_addr_i,
    input wire logic [TRIM_W-1:0] wr_data_i,
    input wire logic [TRIM_AW-1:0] rd_addr_i,
    output logic [TRIM_W-1:0] rd_data_o
);

    ////////////////////////////////////////////////////////////////////
    logic [TRIM_W-1:0] mem [TRIM_DEPTH];

    // One word per channel slot; reset clears to mid-scale, so trims
    // are lost with power and must be rewritten after start-up
    genvar gi;
    generate
        for (gi = 0; gi < TRIM_DEPTH; gi++) begin : g_word
            always_ff @(posedge clk_i or negedge arst_n_i) begin
                if (!arst_n_i) begin
                    mem[gi] <= TRIM_RESET;
                end else if (wr_en_i && wr_addr_i == TRIM_AW'(gi)) begin
                    mem[gi] <= wr_data_i;
                end
            end
        end
    endgenerate

    // Registered read: data one cycle after the address
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rd_data_o <= TRIM_RESET;
        end else begin
            rd_data_o <= mem[rd_addr_i];
        end
    end

    ////////////////////////////////////////////////////////////////////
    chk_trim_readback: assert property (@(posedge clk_i)
        disable iff (!arst_n_i)
        (wr_en_i && rd_addr_i == wr_addr_i)
        ##1 (rd_addr_i == $past(rd_addr_i) && !wr_en_i)
        |=> rd_data_o == $past(wr_data_i, 2))
        else $error("trim word not read back as written");

endmodule // sgrc_trim_mem
`default_nettype wire

/* test/sgrc_ctrl_model.sv */
// Controller model: drives the step clock, ramp reset and direction pins.
// Assumes clk_i is the block clock; every pin level is held at least 8 cycles,
// four times the 2 the pin filters need, so no edge is ever lost.
`timescale 1ns/1ns
`default_nettype none
module sgrc_ctrl_model (
    input wire logic clk_i,
    output logic gain_step_clock_o,
    output logic gain_ramp_reset_o,
    output logic gain_direction_o
);
    ////////////////////////////////////////////////////////////////////
    // Idle pins: ramp held in reset, so nothing steps before we ask
    initial begin
        gain_step_clock_o = 1'b0;
        gain_ramp_reset_o = 1'b1;
        gain_direction_o = 1'b0;
    end

    // One pin change after an edge, then settle past the pin pipeline
    task automatic set_pin(input logic [1:0] pin, input logic val);
        @(posedge clk_i);
        case (pin)
            2'h0: gain_step_clock_o <= val;
            2'h1: gain_ramp_reset_o <= val;
            default: gain_direction_o <= val;
        endcase
        repeat (8) @(posedge clk_i);
        #1;
    endtask

    // Ramp length is the number of whole pulses issued
    task automatic pulse(input int n);
        repeat (n) begin
            set_pin(2'h0, 1'b1);
            set_pin(2'h0, 1'b0);
        end
    endtask
endmodule // sgrc_ctrl_model
`default_nettype wire

/* test/testbench.sv */
// Self-checking bench for the stepped gain ramp control block.
// Assumes the controller model drives the pins; config and trim ports
// are driven here at the rising edge.
`timescale 1ns/1ns
`default_nettype none
module testbench;
    import sgrc_pkg::*;
    logic clk, arst_n, step_clk, ramp_rst, dir, half_dis, wr_en, wr_post;
    logic rd_post, ramp_act, gain_up;
    logic [1:0] range_sel;
    logic [CHAN_W-1:0] wr_chan, rd_chan;
    logic [TRIM_W-1:0] wr_data, rd_data;
    logic [ATT_W-1:0] att;
    int num_errors = 0;
    int cmp_count = 0;
    int cycles = 0;
    ////////////////////////////////////////////////////////////////////
    // 125 MHz clock
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    sgrc_ctrl_model ctl (.clk_i(clk), .gain_step_clock_o(step_clk),
        .gain_ramp_reset_o(ramp_rst), .gain_direction_o(dir));
    sgrc_ramp_ctrl uut (.clk_i(clk), .arst_n_i(arst_n),
        .gain_step_clock_i(step_clk), .gain_ramp_reset_i(ramp_rst),
        .gain_direction_i(dir), .range_sel_i(range_sel),
        .half_step_disable_i(half_dis), .trim_wr_en_i(wr_en),
        .trim_wr_chan_i(wr_chan), .trim_wr_post_i(wr_post),
        .trim_wr_data_i(wr_data), .trim_rd_chan_i(rd_chan),
        .trim_rd_post_i(rd_post), .trim_rd_data_o(rd_data),
        .attenuation_o(att), .ramp_active_o(ramp_act), .gain_up_o(gain_up));
    ////////////////////////////////////////////////////////////////////
    // Ceiling in 0.05 dB units: 38 dB less 2 dB per range code
    function automatic logic [ATT_W-1:0] lim(input logic [1:0] r);
        return ATT_W'((19 - r) * 40);
    endfunction

    task automatic check(input logic [ATT_W-1:0] seen,
                         input logic [ATT_W-1:0] exp, input string what);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value at %0t: %s got %h exp %h", $time, what,
                     seen, exp);
        end
    endtask

    task automatic give_verdict();
        if (num_errors == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Hang guard: the whole run needs about 700 cycles
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            num_errors++;
            give_verdict();
        end
    end
    ////////////////////////////////////////////////////////////////////
    // Initial point per range code and direction; steps ignored in reset
    task automatic t_init();
        for (int r = 0; r < 4; r++) begin
            @(posedge clk);
            range_sel <= 2'(r);
            ctl.set_pin(2'h2, 1'b1);
            check(att, lim(2'(r)), "init up");
            check(ATT_W'(gain_up), 10'h001, "dir");
            ctl.pulse(1);
            check(att, lim(2'(r)), "reset hold");
            ctl.set_pin(2'h2, 1'b0);
            check(att, ATT_MIN, "init down");
        end
    endtask

    // Full steps from the 32 dB ceiling, idle hold, then reset restore
    task automatic t_ramp();
        @(posedge clk);
        range_sel <= RANGE_32DB;
        ctl.set_pin(2'h2, 1'b1);
        check(att, lim(RANGE_32DB), "ceiling");
        ctl.set_pin(2'h1, 1'b0);
        check(ATT_W'(ramp_act), 10'h001, "ramp on");
        ctl.pulse(3);
        check(att, ATT_W'(640 - 3 * UNITS_FULL), "steps");
        repeat (40) @(posedge clk);
        #1;
        check(att, ATT_W'(640 - 3 * UNITS_FULL), "idle");
        ctl.set_pin(2'h1, 1'b1);
        check(att, lim(RANGE_32DB), "restore");
        check(ATT_W'(ramp_act), 10'h000, "ramp off");
    endtask

    // Half steps on both edges both ways, full steps on rising edges only
    task automatic t_half();
        @(posedge clk);
        half_dis <= 1'b0;
        ctl.set_pin(2'h1, 1'b0);
        ctl.set_pin(2'h0, 1'b1);
        check(att, ATT_W'(640 - UNITS_HALF), "half rise");
        ctl.set_pin(2'h0, 1'b0);
        check(att, ATT_W'(640 - UNITS_FULL), "half fall");
        @(posedge clk);
        half_dis <= 1'b1;
        ctl.set_pin(2'h0, 1'b1);
        check(att, ATT_W'(640 - 2 * UNITS_FULL), "full rise");
        ctl.set_pin(2'h0, 1'b0);
        check(att, ATT_W'(640 - 2 * UNITS_FULL), "fall idle");
        ctl.set_pin(2'h1, 1'b1);
        // Gain down from zero attenuation in half-step mode
        ctl.set_pin(2'h2, 1'b0);
        @(posedge clk);
        half_dis <= 1'b0;
        ctl.set_pin(2'h1, 1'b0);
        ctl.set_pin(2'h0, 1'b1);
        check(att, UNITS_HALF, "down rise");
        ctl.set_pin(2'h0, 1'b0);
        check(att, UNITS_FULL, "down fall");
        @(posedge clk);
        half_dis <= 1'b1;
        ctl.set_pin(2'h1, 1'b1);
        ctl.set_pin(2'h2, 1'b1);
    endtask

    // Direction changes mid-ramp, ceiling clamp, range taken at reset
    task automatic t_dir();
        ctl.set_pin(2'h1, 1'b0);
        @(posedge clk);
        range_sel <= RANGE_38DB;
        ctl.set_pin(2'h2, 1'b0);
        ctl.pulse(1);
        check(att, lim(RANGE_32DB), "sync only");
        check(ATT_W'(gain_up), 10'h000, "new dir");
        ctl.pulse(1);
        check(att, lim(RANGE_32DB), "clamp top");
        ctl.set_pin(2'h2, 1'b1);
        ctl.pulse(2);
        check(att, ATT_W'(640 - UNITS_FULL), "up mid");
        ctl.set_pin(2'h2, 1'b0);
        ctl.pulse(2);
        check(att, lim(RANGE_32DB), "down mid");
        ctl.set_pin(2'h2, 1'b1);
        ctl.set_pin(2'h1, 1'b1);
        check(att, lim(RANGE_38DB), "new range");
    endtask

    // Floor clamp at zero attenuation
    task automatic t_floor();
        ctl.set_pin(2'h2, 1'b0);
        ctl.set_pin(2'h1, 1'b0);
        ctl.set_pin(2'h2, 1'b1);
        ctl.pulse(2);
        check(att, ATT_MIN, "clamp zero");
        ctl.set_pin(2'h1, 1'b1);
    endtask

    // Every trim word written back to back, read back; the last one read checked lost on reset
    task automatic t_trim();
        @(posedge clk);
        for (int i = 0; i < TRIM_DEPTH; i++) begin
            wr_en <= 1'b1;
            wr_chan <= CHAN_W'(i >> 1);
            wr_post <= i[0];
            wr_data <= TRIM_W'(i * 13 + 5);
            // Read address follows, but the same-edge read returns the old word, not the one being written
            rd_chan <= CHAN_W'(i >> 1);
            rd_post <= i[0];
            @(posedge clk);
        end
        wr_en <= 1'b0;
        for (int i = 0; i < TRIM_DEPTH; i++) begin
            @(posedge clk);
            rd_chan <= CHAN_W'(i >> 1);
            rd_post <= i[0];
            repeat (2) @(posedge clk);
            #1;
            check(ATT_W'(rd_data), ATT_W'(i * 13 + 5), "trim");
        end
        @(posedge clk);
        arst_n <= 1'b0;
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
        check(ATT_W'(rd_data), ATT_W'(TRIM_RESET), "trim lost");
        check(ATT_W'(ramp_act), 10'h000, "held after reset");
    endtask
    ////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        arst_n = 1'b0;
        half_dis = 1'b1;
        range_sel = RANGE_38DB;
        wr_en = 1'b0;
        wr_chan = '0;
        wr_post = 1'b0;
        wr_data = '0;
        rd_chan = '0;
        rd_post = 1'b0;
        repeat (6) @(posedge clk);
        arst_n <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
        check(att, ATT_MIN, "reset att");
        check(ATT_W'(rd_data), ATT_W'(TRIM_RESET), "reset trim");
        check(ATT_W'(ramp_act), 10'h000, "idle after reset");
        t_init();
        t_ramp();
        t_half();
        t_dir();
        t_floor();
        t_trim();
        give_verdict();
    end
endmodule // testbench
`default_nettype wire
